// *** accel_spi_output_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module accel_spi_output_control #(
   parameter int SAMPLE_W = accel_spi_pkg::SAMPLE_BITS,
   parameter int FIFO_D = accel_spi_pkg::FIFO_DEPTH
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic SCK,
   input wire logic FRAME_SELECT_N,
   input wire logic MOSI,
   output logic MISO,
   input wire logic [SAMPLE_W-1:0] X_SAMPLE,
   input wire logic [SAMPLE_W-1:0] Y_SAMPLE,
   input wire logic SAMPLE_VALID,
   output logic SAMPLE_READY,
   input wire logic POWERED_DOWN,
   input wire logic HEATER_LOOP_ERROR,
   input wire logic SELF_TEST_ACTIVE,
   output logic FILTER_RESET,
   output logic [1:0] FILTER_TEST_MODE
);
   import accel_spi_pkg::*;

   logic [FRAME_BITS-1:0] rx_word, resp_r, resp_nxt;
   logic frame_end, count_ok, miso_w;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [1:0] ftest_r;
   logic [SAMPLE_W-1:0] ch_x_r, ch_y_r;
   logic frz_x_r, frz_y_r, frz_x_nxt, frz_y_nxt;
   logic [3:0] seen_r, seen_nxt;
   logic [2*SAMPLE_W-1:0] fifo_out;
   logic fifo_valid, fifo_ready, fifo_in_ready;
   logic sensor_req, reg_write, reg_read, sample_read, ctrl_written;
   logic [1:0] req_op, chan;
   update_mode_type mode;

   spi_frame_shifter #(
      .FRAME_BITS(FRAME_BITS)
   ) shifter_i (
      .clk(CLK),
      .resetn(RESETN),
      .sck(SCK),
      .sel_n(FRAME_SELECT_N),
      .mosi(MOSI),
      .tx_word(resp_r),
      .miso(miso_w),
      .frame_end(frame_end),
      .rx_word(rx_word),
      .count_ok(count_ok)
   );

   assign MISO = miso_w;

   // Samples wait here while the output registers are frozen
   sample_fifo #(
      .WIDTH(2 * SAMPLE_W),
      .DEPTH(FIFO_D)
   ) fifo_i (
      .clk(CLK),
      .resetn(RESETN),
      .clear(ctrl_r[CTRL_FRESET_BIT]),
      .in_data({X_SAMPLE, Y_SAMPLE}),
      .in_valid(SAMPLE_VALID),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready)
   );

   assign SAMPLE_READY = fifo_in_ready;

   // Request decode
   assign mode = update_mode_type'(ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO]);
   assign sensor_req = rx_word[REQ_SENSOR_BIT];
   assign req_op = rx_word[REQ_OP_HI:REQ_OP_LO];
   assign chan = rx_word[1:0];
   assign sample_read = frame_end & count_ok & sensor_req;
   assign reg_write = frame_end & count_ok & ~sensor_req & (req_op == OP_WRITE);
   assign reg_read = frame_end & count_ok & ~sensor_req & (req_op == OP_READ);
   assign ctrl_written = reg_write;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (reg_write) begin
         ctrl_nxt = rx_word[REQ_DATA_HI:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign FILTER_RESET = ctrl_r[CTRL_FRESET_BIT];

   // Only the defined test code reaches the filters; the rest run them normally
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ftest_r <= FTEST_NORMAL;
      end else if (ctrl_r[CTRL_FTEST_HI:CTRL_FTEST_LO] == FTEST_BYPASS) begin
         ftest_r <= FTEST_BYPASS;
      end else begin
         ftest_r <= FTEST_NORMAL;
      end
   end

   assign FILTER_TEST_MODE = ftest_r;

   // Freeze bookkeeping; seen bits are indexed by the channel selector
   always_comb begin
      frz_x_nxt = frz_x_r;
      frz_y_nxt = frz_y_r;
      seen_nxt = seen_r;
      if (ctrl_written || ctrl_r[CTRL_FRESET_BIT]) begin
         frz_x_nxt = 1'b0;
         frz_y_nxt = 1'b0;
         seen_nxt = 4'h0;
      end else if (sample_read) begin
         unique case (mode)
            MODE_FREEZE_ALL: begin
               seen_nxt = seen_r | (4'h1 << chan);
               frz_x_nxt = 1'b1;
               frz_y_nxt = 1'b1;
               if (seen_nxt == 4'hF) begin
                  frz_x_nxt = 1'b0;
                  frz_y_nxt = 1'b0;
                  seen_nxt = 4'h0;
               end
            end
            MODE_FREEZE_CHAN: begin
               seen_nxt = seen_r | (4'h1 << chan);
               if (seen_nxt[SEL_X_LOW] && seen_nxt[SEL_X_HIGH]) begin
                  frz_x_nxt = 1'b0;
                  seen_nxt[SEL_X_LOW] = 1'b0;
                  seen_nxt[SEL_X_HIGH] = 1'b0;
               end else if (!chan[0]) begin
                  frz_x_nxt = 1'b1;
               end
               if (seen_nxt[SEL_Y_LOW] && seen_nxt[SEL_Y_HIGH]) begin
                  frz_y_nxt = 1'b0;
                  seen_nxt[SEL_Y_LOW] = 1'b0;
                  seen_nxt[SEL_Y_HIGH] = 1'b0;
               end else if (chan[0]) begin
                  frz_y_nxt = 1'b1;
               end
            end
            MODE_FREEZE_HIGH: begin
               // Low-byte reads leave the freeze untouched in this mode
               if (chan[1]) begin
                  seen_nxt = seen_r | (4'h1 << chan);
                  frz_x_nxt = 1'b1;
                  frz_y_nxt = 1'b1;
                  if (seen_nxt[SEL_X_HIGH] && seen_nxt[SEL_Y_HIGH]) begin
                     frz_x_nxt = 1'b0;
                     frz_y_nxt = 1'b0;
                     seen_nxt = 4'h0;
                  end
               end
            end
            MODE_CONTINUOUS: begin
               frz_x_nxt = 1'b0;
               frz_y_nxt = 1'b0;
               seen_nxt = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         frz_x_r <= 1'b0;
         frz_y_r <= 1'b0;
         seen_r <= 4'h0;
      end else begin
         frz_x_r <= frz_x_nxt;
         frz_y_r <= frz_y_nxt;
         seen_r <= seen_nxt;
      end
   end

   // A half-frozen pair still drains, so the live axis keeps tracking
   assign fifo_ready = ~(frz_x_r & frz_y_r);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ch_x_r <= '0;
         ch_y_r <= '0;
      end else if (ctrl_r[CTRL_FRESET_BIT]) begin
         ch_x_r <= '0;
         ch_y_r <= '0;
      end else if (fifo_valid && fifo_ready) begin
         if (!frz_x_r) begin
            ch_x_r <= fifo_out[2*SAMPLE_W-1:SAMPLE_W];
         end
         if (!frz_y_r) begin
            ch_y_r <= fifo_out[SAMPLE_W-1:0];
         end
      end
   end

   // Response for this request, shifted out during the next frame
   function automatic logic [FRAME_BITS-1:0] with_parity(input logic [FRAME_BITS-1:0] w);
      logic [FRAME_BITS-1:0] r;
      r = w;
      r[RSP_PARITY_BIT] = 1'b0;
      r[RSP_PARITY_BIT] = ~^r;
      return r;
   endfunction

   always_comb begin
      logic [SAMPLE_W-1:0] sel_sample;
      logic [HIGH_BITS-1:0] payload;
      resp_nxt = '0;
      sel_sample = chan[0] ? ch_y_r : ch_x_r;
      payload = chan[1] ? sel_sample[SAMPLE_W-1:LOW_BITS]
                        : {{(HIGH_BITS - LOW_BITS){1'b0}}, sel_sample[LOW_BITS-1:0]};
      resp_nxt[11:10] = STATUS_OTHER;
      resp_nxt[9:8] = EXCEPT_OTHER;
      if (!count_ok) begin
         resp_nxt[RSP_FRAME_ERR_BIT] = 1'b1;
      end else if (sensor_req) begin
         resp_nxt[15:13] = {rx_word[REQ_TAG_MID], rx_word[REQ_OP_HI:REQ_OP_LO]};
         if (POWERED_DOWN || HEATER_LOOP_ERROR) begin
            resp_nxt[RSP_ERR_PD_BIT] = POWERED_DOWN;
            resp_nxt[RSP_ERR_HEAT_BIT] = HEATER_LOOP_ERROR;
         end else begin
            resp_nxt[11:10] = SELF_TEST_ACTIVE ? STATUS_SELFTEST : STATUS_SAMPLE;
            resp_nxt[9:0] = payload;
         end
      end else if (reg_write) begin
         resp_nxt[14:RSP_OP_LO] = req_op;
         resp_nxt[7:0] = rx_word[REQ_DATA_HI:0];
      end else if (reg_read) begin
         resp_nxt[14:RSP_OP_LO] = req_op;
         resp_nxt[7:0] = ctrl_r;
      end else begin
         resp_nxt[RSP_REQ_ERR_BIT] = 1'b1;
      end
      resp_nxt = with_parity(resp_nxt);
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         resp_r <= RESP_AFTER_RESET;
      end else if (frame_end) begin
         resp_r <= resp_nxt;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   a_resp_odd_parity: assert property (^resp_r == 1'b1)
      else $error("response parity is not odd");

   a_ctrl_write_loads: assert property (reg_write |=> ctrl_r == $past(rx_word[7:0]))
      else $error("control write did not load the data byte");

   a_nonsensor_status: assert property (frame_end && !(count_ok && sensor_req)
      |=> resp_r[11:8] == {STATUS_OTHER, EXCEPT_OTHER})
      else $error("non-sensor response status wrong");

   a_framing_error: assert property (frame_end && !count_ok |=> resp_r[2] && ctrl_r == $past(ctrl_r))
      else $error("framing error not flagged or request executed");

   a_request_error: assert property (frame_end && count_ok && !sensor_req
      && req_op != OP_WRITE && req_op != OP_READ |=> resp_r[1] && resp_r[14:13] == 2'h0)
      else $error("unknown request not flagged");

   a_opcode_echo: assert property (reg_read |=> resp_r[14:13] == OP_READ
      && resp_r[7:0] == $past(ctrl_r))
      else $error("read response lacks opcode or data");

   a_filter_zero: assert property (ctrl_r[CTRL_FRESET_BIT] |=> ch_x_r == '0 && ch_y_r == '0)
      else $error("outputs not zero in filter reset");

   a_frozen_hold: assert property (frz_x_r && !ctrl_r[CTRL_FRESET_BIT] |=> $stable(ch_x_r))
      else $error("frozen axis changed");

   a_continuous_free: assert property (mode == MODE_CONTINUOUS && !frz_x_r && !frz_y_r
      |=> !frz_x_r && !frz_y_r)
      else $error("continuous mode froze an output");

   a_sensor_errors: assert property (sample_read && POWERED_DOWN |=> resp_r[3] && resp_r[11:10] == STATUS_OTHER)
      else $error("power-down flag missing");

   a_all_freeze: assert property (sample_read && mode == MODE_FREEZE_ALL && !ctrl_r[CTRL_FRESET_BIT]
      && seen_r == 4'h0 |=> frz_x_r && frz_y_r)
      else $error("first read did not freeze both axes");

   a_frozen_y_hold: assert property (frz_y_r && !ctrl_r[CTRL_FRESET_BIT] |=> $stable(ch_y_r))
      else $error("frozen second axis changed");

   a_selftest_status: assert property (sample_read && SELF_TEST_ACTIVE && !POWERED_DOWN && !HEATER_LOOP_ERROR
      |=> resp_r[11:10] == STATUS_SELFTEST)
      else $error("self-test status missing");

   a_low_byte_pad: assert property (sample_read && !chan[1] && !POWERED_DOWN && !HEATER_LOOP_ERROR
      |=> resp_r[HIGH_BITS-1:LOW_BITS] == '0)
      else $error("low byte response not zero padded");

   a_tag_echo: assert property (sample_read |=> resp_r[15:13] == $past({rx_word[REQ_TAG_MID], req_op}))
      else $error("sequence tag not echoed");

   a_write_echo: assert property (reg_write |=> resp_r[14:13] == OP_WRITE
      && resp_r[7:0] == $past(rx_word[7:0]))
      else $error("write response lacks opcode or data");

   c_sensor_read: cover property (sample_read ##1 resp_r[11:10] == STATUS_SAMPLE);
   c_ctrl_write: cover property (reg_write);
   c_frame_error: cover property (frame_end && !count_ok);
   c_fifo_full: cover property (!SAMPLE_READY && frz_x_r && frz_y_r);
   c_high_unfreeze: cover property (sample_read && mode == MODE_FREEZE_HIGH && seen_r[SEL_Y_HIGH] && chan == SEL_X_HIGH);
endmodule // accel_spi_output_control
`default_nettype wire

// *** accel_spi_pkg.sv ***
package accel_spi_pkg;
   localparam int FRAME_BITS = 16;
   localparam int SAMPLE_BITS = 14;
   localparam int HIGH_BITS = 10;
   localparam int LOW_BITS = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 20;

   // Request word fields
   localparam int REQ_SENSOR_BIT = 13;
   localparam int REQ_OP_HI = 15;
   localparam int REQ_OP_LO = 14;
   localparam int REQ_TAG_MID = 12;
   localparam int REQ_CHAN_HI = 3;
   localparam int REQ_DATA_HI = 7;

   // Response word fields
   localparam int RSP_PARITY_BIT = 12;
   localparam int RSP_OP_LO = 13;
   localparam int RSP_ERR_PD_BIT = 3;
   localparam int RSP_ERR_HEAT_BIT = 2;
   localparam int RSP_FRAME_ERR_BIT = 2;
   localparam int RSP_REQ_ERR_BIT = 1;
   localparam int RSP_UNAVAIL_BIT = 0;

   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] STATUS_SAMPLE = 2'h1;
   localparam logic [1:0] STATUS_SELFTEST = 2'h2;
   localparam logic [1:0] STATUS_OTHER = 2'h3;
   localparam logic [1:0] EXCEPT_OTHER = 2'h2;
   localparam logic [15:0] RESP_AFTER_RESET = 16'h0E03;

   // Channel selector low bits
   localparam logic [1:0] SEL_X_LOW = 2'h0;
   localparam logic [1:0] SEL_Y_LOW = 2'h1;
   localparam logic [1:0] SEL_X_HIGH = 2'h2;
   localparam logic [1:0] SEL_Y_HIGH = 2'h3;

   // Control register layout
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_MODE_HI = 1;
   localparam int CTRL_FRESET_BIT = 2;
   localparam int CTRL_FTEST_LO = 3;
   localparam int CTRL_FTEST_HI = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef enum logic [1:0] {
      MODE_FREEZE_ALL = 2'b00,
      MODE_FREEZE_CHAN = 2'b01,
      MODE_FREEZE_HIGH = 2'b10,
      MODE_CONTINUOUS = 2'b11
   } update_mode_type;

   localparam logic [1:0] FTEST_NORMAL = 2'h0;
   localparam logic [1:0] FTEST_BYPASS = 2'h1;
endpackage

// *** sample_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, rd_r;
   logic [CW-1:0] count_r, count_nxt;
   logic push, pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_r];

   always_comb begin
      count_nxt = count_r;
      if (clear) begin
         count_nxt = '0;
      end else if (push && !pop) begin
         count_nxt = count_r + CW'(1);
      end else if (pop && !push) begin
         count_nxt = count_r - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= '0;
         in_ready <= 1'b1;
      end else begin
         count_r <= count_nxt;
         // Registered ready keeps the pin glitch free; it is exact because it uses the next count
         in_ready <= (count_nxt != CW'(DEPTH));
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_r <= '0;
         rd_r <= '0;
      end else if (clear) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push && !clear) begin
         mem_r[wr_r] <= in_data;
      end
   end
endmodule // sample_fifo
`default_nettype wire

// *** spi_frame_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_frame_shifter #(
   parameter int FRAME_BITS = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sck,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic [FRAME_BITS-1:0] tx_word,
   output logic miso,
   output logic frame_end,
   output logic [FRAME_BITS-1:0] rx_word,
   output logic count_ok
);
   localparam int CW = $clog2(FRAME_BITS + 2);
   logic [1:0] sck_s, sel_s, mosi_s;
   logic sck_d, sel_d;
   logic [CW-1:0] cnt_r;
   logic [FRAME_BITS-1:0] tx_r;
   logic rise, fall, start, stop, active;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sck_s <= 2'h0;
         sel_s <= 2'h3;
         mosi_s <= 2'h0;
         sck_d <= 1'b0;
         sel_d <= 1'b1;
      end else begin
         sck_s <= {sck_s[0], sck};
         sel_s <= {sel_s[0], sel_n};
         mosi_s <= {mosi_s[0], mosi};
         sck_d <= sck_s[1];
         sel_d <= sel_s[1];
      end
   end

   assign rise = sck_s[1] & ~sck_d;
   assign fall = ~sck_s[1] & sck_d;
   assign active = ~sel_s[1];
   assign start = ~sel_s[1] & sel_d;
   assign stop = sel_s[1] & ~sel_d;
   assign count_ok = (cnt_r == CW'(FRAME_BITS));
   assign miso = tx_r[FRAME_BITS-1];

   // Edge count saturates so a long burst can never wrap back to a legal count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (start) begin
         cnt_r <= '0;
      end else if (rise && active && cnt_r != CW'(FRAME_BITS + 1)) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_word <= '0;
      end else if (rise && active) begin
         rx_word <= {rx_word[FRAME_BITS-2:0], mosi_s[1]};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_r <= '0;
      end else if (start) begin
         tx_r <= tx_word;
      end else if (fall && active) begin
         tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frame_end <= 1'b0;
      end else begin
         frame_end <= stop;
      end
   end
endmodule // spi_frame_shifter
`default_nettype wire

// *** spi_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input wire logic clk,
   output var logic sck,
   output var logic sel_n,
   output var logic mosi,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      sel_n = 1'b1;
      mosi = 1'b0;
   end

   // Clock stands low between frames; MISO is taken at the falling edge,
   // late in the bit, to leave margin for the slave's pin synchronisers
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      sel_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         mosi <= (i < 16) ? w[15-i] : 1'b0;
         repeat (4) @(posedge clk);
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         r = {r[14:0], miso};
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      sel_n <= 1'b1;
      // Released data line shows the inverse so a stale bit is never reused
      mosi <= ~mosi;
      repeat (12) @(posedge clk);
   endtask
endmodule // spi_master_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import accel_spi_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic sck;
   logic sel_n;
   logic mosi;
   logic miso;
   logic [13:0] x_s = 14'h0000;
   logic [13:0] y_s = 14'h0000;
   logic s_valid = 1'b0;
   logic s_ready;
   logic pd = 1'b0;
   logic he = 1'b0;
   logic st = 1'b0;
   logic f_reset;
   logic [1:0] f_test;
   int fails = 0;
   int check_count = 0;
   logic [15:0] prev;
   int n;

   accel_spi_output_control dut (.CLK(clk), .RESETN(resetn), .SCK(sck), .FRAME_SELECT_N(sel_n), .MOSI(mosi),
      .MISO(miso), .X_SAMPLE(x_s), .Y_SAMPLE(y_s), .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready),
      .POWERED_DOWN(pd), .HEATER_LOOP_ERROR(he), .SELF_TEST_ACTIVE(st), .FILTER_RESET(f_reset),
      .FILTER_TEST_MODE(f_test));
   spi_master_model m (.clk(clk), .sck(sck), .sel_n(sel_n), .mosi(mosi), .miso(miso));

   initial begin
      forever #10 clk = ~clk;
   end

   function automatic logic [15:0] par(input logic [15:0] w);
      par = w;
      par[RSP_PARITY_BIT] = ~^w;
   endfunction
   function automatic logic [15:0] ctl(input logic [1:0] op, input logic [7:0] d);
      ctl = par({1'b0, op, 1'b0, STATUS_OTHER, EXCEPT_OTHER, d});
   endfunction
   function automatic logic [15:0] sreq(input logic [2:0] tag, input logic [1:0] sel);
      sreq = {tag[1], tag[0], 1'b1, tag[2], 8'hA5, 2'h2, sel};
   endfunction
   function automatic logic [15:0] sensor_request_flag(input logic [15:0] rq, input logic [1:0] s, input logic [9:0] p);
      sensor_request_flag = par({rq[12], rq[15], rq[14], 1'b0, s, p});
   endfunction
   function automatic logic [15:0] wr(input logic [7:0] d);
      wr = {OP_WRITE, 1'b0, 5'h15, d};
   endfunction
   localparam logic [15:0] RD = {OP_READ, 1'b0, 5'h0A, 8'h3C};
   localparam logic [9:0] PD_ERR = 10'h208;
   localparam logic [9:0] HEAT_ERR = 10'h204;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sx(input logic [15:0] req, input logic [15:0] exp);
      logic [15:0] r;
      m.xfer(req, 16, r);
      check(r, exp);
   endtask
   task automatic push(input logic [13:0] x, input logic [13:0] y);
      int k;
      k = 0;
      @(posedge clk);
      x_s <= x;
      y_s <= y;
      s_valid <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (s_ready !== 1'b1 && k < 50);
      s_valid <= 1'b0;
      x_s <= ~x;
      y_s <= ~y;
      check(16'(k < 50), 16'h0001);
   endtask

   task automatic t_reset();
      check({14'h0000, f_reset, f_test[0]}, 16'h0000);
      sx(wr(8'hE3), RESP_AFTER_RESET);
      sx(RD, ctl(OP_WRITE, 8'hE3));
      sx(RD, ctl(OP_READ, 8'hE3));
      $display("t_reset done");
   endtask
   task automatic t_errors();
      logic [15:0] r;
      sx(16'h0012, ctl(OP_READ, 8'hE3));
      sx(16'hC055, ctl(2'h0, 8'h02));
      m.xfer(wr(8'h00), 15, r);
      sx(RD, ctl(2'h0, 8'h04));
      m.xfer(wr(8'h00), 17, r);
      sx(RD, ctl(2'h0, 8'h04));
      sx(RD, ctl(OP_READ, 8'hE3));
      $display("t_errors done");
   endtask
   task automatic t_ftest();
      prev = ctl(OP_READ, 8'hE3);
      for (int ft = 0; ft < 4; ft++) begin
         sx(wr({3'h0, 2'(ft), 3'h3}), prev);
         prev = ctl(OP_WRITE, {3'h0, 2'(ft), 3'h3});
         check({14'h0000, f_test}, (ft == 1) ? 16'h0001 : 16'h0000);
      end
      sx(wr(8'h07), prev);
      check({15'h0000, f_reset}, 16'h0001);
      push(14'h1234, 14'h0567);
      sx(sreq(3'h5, SEL_X_HIGH), ctl(OP_WRITE, 8'h07));
      sx(sreq(3'h3, SEL_Y_LOW), sensor_request_flag(sreq(3'h5, SEL_X_HIGH), STATUS_SAMPLE, 10'h000));
      sx(wr(8'h03), sensor_request_flag(sreq(3'h3, SEL_Y_LOW), STATUS_SAMPLE, 10'h000));
      check({15'h0000, f_reset}, 16'h0000);
      $display("t_ftest done");
   endtask
   task automatic t_cont();
      push(14'h3FFF, 14'h2800);
      sx(sreq(3'h1, SEL_X_HIGH), ctl(OP_WRITE, 8'h03));
      // The high-byte read must not freeze X, so the next sample lands before the low-byte read
      push(14'h0320, 14'h3CE5);
      sx(sreq(3'h6, SEL_X_LOW), sensor_request_flag(sreq(3'h1, SEL_X_HIGH), STATUS_SAMPLE, 10'h3FF));
      sx(sreq(3'h7, SEL_Y_HIGH), sensor_request_flag(sreq(3'h6, SEL_X_LOW), STATUS_SAMPLE, 10'h000));
      st <= 1'b1;
      sx(sreq(3'h2, SEL_Y_LOW), sensor_request_flag(sreq(3'h7, SEL_Y_HIGH), STATUS_SAMPLE, 10'h3CE));
      st <= 1'b0;
      pd <= 1'b1;
      sx(sreq(3'h4, SEL_X_HIGH), sensor_request_flag(sreq(3'h2, SEL_Y_LOW), STATUS_SELFTEST, 10'h005));
      pd <= 1'b0;
      he <= 1'b1;
      sx(sreq(3'h4, SEL_X_HIGH), sensor_request_flag(sreq(3'h4, SEL_X_HIGH), STATUS_OTHER, PD_ERR));
      he <= 1'b0;
      sx(RD, sensor_request_flag(sreq(3'h4, SEL_X_HIGH), STATUS_OTHER, HEAT_ERR));
      $display("t_cont done");
   endtask
   task automatic t_freeze_all();
      sx(wr(8'h00), ctl(OP_READ, 8'h03));
      push(14'h1ABC, 14'h0DEF);
      sx(sreq(3'h1, SEL_X_HIGH), ctl(OP_WRITE, 8'h00));
      push(14'h2222, 14'h3333);
      sx(sreq(3'h2, SEL_Y_LOW), sensor_request_flag(sreq(3'h1, SEL_X_HIGH), STATUS_SAMPLE, 10'h1AB));
      sx(sreq(3'h3, SEL_X_LOW), sensor_request_flag(sreq(3'h2, SEL_Y_LOW), STATUS_SAMPLE, 10'h00F));
      sx(sreq(3'h4, SEL_Y_HIGH), sensor_request_flag(sreq(3'h3, SEL_X_LOW), STATUS_SAMPLE, 10'h00C));
      sx(sreq(3'h5, SEL_X_HIGH), sensor_request_flag(sreq(3'h4, SEL_Y_HIGH), STATUS_SAMPLE, 10'h0DE));
      // Both axes frozen now, so the buffer must take exactly its depth
      n = 0;
      @(posedge clk);
      x_s <= 14'h0555;
      y_s <= 14'h0AAA;
      s_valid <= 1'b1;
      repeat (12) begin
         @(posedge clk);
         if (s_ready === 1'b1) n++;
      end
      s_valid <= 1'b0;
      check(16'(n), 16'h0008);
      sx(RD, sensor_request_flag(sreq(3'h5, SEL_X_HIGH), STATUS_SAMPLE, 10'h222));
      $display("t_freeze_all done");
   endtask
   task automatic t_mode01();
      sx(wr(8'h01), ctl(OP_READ, 8'h00));
      push(14'h1111, 14'h2FF2);
      sx(sreq(3'h1, SEL_X_HIGH), ctl(OP_WRITE, 8'h01));
      push(14'h3C3C, 14'h0707);
      sx(sreq(3'h2, SEL_Y_HIGH), sensor_request_flag(sreq(3'h1, SEL_X_HIGH), STATUS_SAMPLE, 10'h111));
      sx(sreq(3'h3, SEL_X_LOW), sensor_request_flag(sreq(3'h2, SEL_Y_HIGH), STATUS_SAMPLE, 10'h070));
      sx(RD, sensor_request_flag(sreq(3'h3, SEL_X_LOW), STATUS_SAMPLE, 10'h001));
      $display("t_mode01 done");
   endtask
   task automatic t_mode10();
      sx(wr(8'h02), ctl(OP_READ, 8'h01));
      push(14'h0FA7, 14'h3060);
      sx(sreq(3'h1, SEL_Y_HIGH), ctl(OP_WRITE, 8'h02));
      push(14'h2800, 14'h1800);
      sx(sreq(3'h2, SEL_X_LOW), sensor_request_flag(sreq(3'h1, SEL_Y_HIGH), STATUS_SAMPLE, 10'h306));
      sx(sreq(3'h3, SEL_X_HIGH), sensor_request_flag(sreq(3'h2, SEL_X_LOW), STATUS_SAMPLE, 10'h007));
      sx(RD, sensor_request_flag(sreq(3'h3, SEL_X_HIGH), STATUS_SAMPLE, 10'h0FA));
      sx(sreq(3'h4, SEL_X_HIGH), ctl(OP_READ, 8'h02));
      sx(RD, sensor_request_flag(sreq(3'h4, SEL_X_HIGH), STATUS_SAMPLE, 10'h280));
      $display("t_mode10 done");
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_errors();
      t_ftest();
      t_cont();
      t_freeze_all();
      t_mode01();
      t_mode10();
      stop_test();
   end

   // Seven scenarios of some 45 frames need about 135 us
   initial begin
      #400us;
      fails++;
      stop_test();
   end
endmodule // tb
`default_nettype wire
